/* File: verilog/trc_relay.sv */
// Threshold relay controller with relay LED and general alarm LED.
`timescale 1ns/1ps
// How it works
// - Output mode picks unused, one or two setpoints.
// - Change only past a border after the delay.
// - Zero delays switch immediately at a border.
// - Turn on after dwell of turn-on delay.
// - Turn off after turn-off delay elapses.
// - Leaving zone early keeps relay state.
// - Mode decides relay state in zone A.
// - Alarm setting forces on, off or keeps.
// - Two setpoints share all other settings.
// - Inside or outside zone turns relay on.
// - Setpoints may come in either order.
// - Compare present value or held peak.
// - Relay LED dark when open, flashes closed.
// - Alarm LED green normally, red on alarm.
// - Alarm LED flashes outside display temperature range.
module trc_relay (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic signed [15:0] meas_value,
  input wire logic signed [15:0] peak_value,
  input wire logic peak_active,
  input wire logic [1:0] out_mode,
  input wire logic mode_on_in,
  input wire logic signed [15:0] first_setpoint,
  input wire logic signed [15:0] second_setpoint,
  input wire logic [15:0] hysteresis,
  input wire logic [15:0] turn_on_delay,
  input wire logic [15:0] turn_off_delay,
  input wire logic [1:0] time_unit,
  input wire logic [1:0] alarm_mode,
  input wire logic critical,
  input wire logic any_input_alarm,
  input wire logic signed [15:0] display_temp,
  output logic relay_on,
  output logic relay_led_red,
  output logic general_alarm_led_green,
  output logic general_alarm_led_red
);

  logic tick_ms;
  logic signed [17:0] val;
  logic signed [17:0] lo_sp;
  logic signed [17:0] hi_sp;
  logic signed [17:0] hyst;
  trc_pkg::trc_zone_t zone;
  logic want;
  logic want_valid;
  logic [31:0] scale;
  logic [31:0] on_lim;
  logic [31:0] off_lim;
  logic [31:0] lim;

  logic relay_q;
  logic relay_d;
  trc_pkg::trc_state_t st_q;
  trc_pkg::trc_state_t st_d;
  logic target_q;
  logic target_d;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic [15:0] blink_cnt_q;
  logic [15:0] blink_cnt_d;
  logic blink_q;
  logic blink_d;
  logic led_q;
  logic led_d;
  logic grn_q;
  logic grn_d;
  logic red_q;
  logic red_d;

  trc_tick u_tick (
    .core_clk(core_clk),
    .reset(reset),
    .tick_ms(tick_ms)
  );

  // ----------------------------------------------------------------------
  // Zone detection
  // ----------------------------------------------------------------------
  // Widened arithmetic so setpoint plus hysteresis never wraps.
  always_comb
  begin
    val = peak_active ? 18'(peak_value) : 18'(meas_value);
    hyst = $signed({2'b00, hysteresis});
    if (first_setpoint <= second_setpoint)
    begin
      lo_sp = 18'(first_setpoint);
      hi_sp = 18'(second_setpoint);
    end
    else
    begin
      lo_sp = 18'(second_setpoint);
      hi_sp = 18'(first_setpoint);
    end
    zone = trc_pkg::ZONE_MID;
    want = relay_q;
    want_valid = 1'b0;
    case (out_mode)
      trc_pkg::OUT_ONE:
      begin
        if (val > 18'(first_setpoint) + hyst)
          zone = trc_pkg::ZONE_A;
        else if (val < 18'(first_setpoint) - hyst)
          zone = trc_pkg::ZONE_B;
        want_valid = (zone != trc_pkg::ZONE_MID);
        want = (zone == trc_pkg::ZONE_A) ? mode_on_in : !mode_on_in;
      end
      trc_pkg::OUT_TWO:
      begin
        if (val > lo_sp + hyst && val < hi_sp - hyst)
          zone = trc_pkg::ZONE_A;
        else if (val < lo_sp - hyst || val > hi_sp + hyst)
          zone = trc_pkg::ZONE_B;
        want_valid = (zone != trc_pkg::ZONE_MID);
        want = (zone == trc_pkg::ZONE_A) ? mode_on_in : !mode_on_in;
      end
      default:
      begin
        want_valid = 1'b0;
        want = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Delay limits
  // ----------------------------------------------------------------------
  // Delays are counted in milliseconds scaled by the time unit.
  // The largest delay in minutes still fits the 32-bit limit.
  always_comb
  begin
    case (time_unit)
      trc_pkg::UNIT_S: scale = trc_pkg::MS_PER_S;
      trc_pkg::UNIT_MIN: scale = trc_pkg::MS_PER_MIN;
      default: scale = 32'h0000_0001;
    endcase
    on_lim = 32'(turn_on_delay * scale);
    off_lim = 32'(turn_off_delay * scale);
    lim = target_q ? on_lim : off_lim;
  end

  // ----------------------------------------------------------------------
  // Relay state machine
  // ----------------------------------------------------------------------
  // The relay moves from idle on a zero delay, or from wait at the limit.
  always_comb
  begin
    relay_d = relay_q;
    st_d = st_q;
    target_d = target_q;
    cnt_d = cnt_q;
    case (st_q)
      trc_pkg::ST_IDLE:
      begin
        cnt_d = 32'h0000_0000;
        if (want_valid && want != relay_q)
        begin
          if ((want ? on_lim : off_lim) == 32'h0000_0000)
            relay_d = want;
          else
          begin
            st_d = trc_pkg::ST_WAIT;
            target_d = want;
          end
        end
      end
      trc_pkg::ST_WAIT:
      begin
        if (!want_valid || want != target_q)
        begin
          st_d = trc_pkg::ST_IDLE;
          cnt_d = 32'h0000_0000;
        end
        else if (cnt_q >= lim)
        begin
          relay_d = target_q;
          st_d = trc_pkg::ST_IDLE;
        end
        else if (tick_ms)
          cnt_d = cnt_q + 32'h0000_0001;
      end
      default:
        st_d = trc_pkg::ST_IDLE;
    endcase
    // Unused relay stays open; a critical override below can still force it on.
    // The spare mode code is treated as unused as well.
    if (out_mode != trc_pkg::OUT_ONE && out_mode != trc_pkg::OUT_TWO)
    begin
      relay_d = 1'b0;
      st_d = trc_pkg::ST_IDLE;
    end
    // Critical override.
    // It also parks the timer, so a dwell begun before the fault cannot
    // complete behind it.
    if (critical)
    begin
      st_d = trc_pkg::ST_IDLE;
      cnt_d = 32'h0000_0000;
      if (alarm_mode == trc_pkg::ALM_ON)
        relay_d = 1'b1;
      else if (alarm_mode == trc_pkg::ALM_OFF)
        relay_d = 1'b0;
      else
        relay_d = relay_q;
    end
  end

  // Relay state registers; reset leaves the relay open and the timer idle.
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      relay_q <= trc_pkg::RELAY_RST;
      st_q <= trc_pkg::ST_IDLE;
      target_q <= 1'b0;
      cnt_q <= 32'h0000_0000;
    end
    else
    begin
      relay_q <= relay_d;
      st_q <= st_d;
      target_q <= target_d;
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------------------------------------
  // LEDs
  // ----------------------------------------------------------------------
  // One blink phase drives both flashing LEDs so they stay in step.
  always_comb
  begin
    blink_cnt_d = blink_cnt_q;
    blink_d = blink_q;
    if (tick_ms)
    begin
      if (blink_cnt_q == trc_pkg::BLINK_TICKS - 16'h0001)
      begin
        blink_cnt_d = 16'h0000;
        blink_d = !blink_q;
      end
      else
        blink_cnt_d = blink_cnt_q + 16'h0001;
    end
    led_d = relay_d & blink_d;
    red_d = any_input_alarm;
    grn_d = !any_input_alarm;
    if (display_temp < trc_pkg::TEMP_MIN_C ||
        display_temp > trc_pkg::TEMP_MAX_C)
    begin
      red_d = red_d & blink_d;
      grn_d = grn_d & blink_d;
    end
  end

  // LED registers; all LEDs are dark during reset.
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      blink_cnt_q <= 16'h0000;
      blink_q <= 1'b0;
      led_q <= 1'b0;
      grn_q <= 1'b0;
      red_q <= 1'b0;
    end
    else
    begin
      blink_cnt_q <= blink_cnt_d;
      blink_q <= blink_d;
      led_q <= led_d;
      grn_q <= grn_d;
      red_q <= red_d;
    end
  end

  assign relay_on = relay_q;
  assign relay_led_red = led_q;
  assign general_alarm_led_green = grn_q;
  assign general_alarm_led_red = red_q;

endmodule

/* File: shared/trc_pkg.sv */
// Package with the shared constants and types of the threshold relay block.
package trc_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int VAL_W = 16;
  localparam int DLY_W = 16;
  localparam int CNT_W = 32;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_MS_NS = 1000000;
  localparam int TICK_MS_CYC = TICK_MS_NS / CLK_PERIOD_NS;
  localparam int BLINK_MS = 500;
  localparam logic [15:0] BLINK_TICKS = 16'(BLINK_MS);

  // Display temperature working range in degrees Celsius.
  localparam logic signed [VAL_W-1:0] TEMP_MIN_C = -16'sd20;
  localparam logic signed [VAL_W-1:0] TEMP_MAX_C = 16'sd70;

  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  // Output mode: relay unused, one threshold, two thresholds.
  localparam logic [1:0] OUT_UNUSED = 2'h0;
  localparam logic [1:0] OUT_ONE = 2'h1;
  localparam logic [1:0] OUT_TWO = 2'h2;

  // Alarm behaviour in critical situations.
  localparam logic [1:0] ALM_KEEP = 2'h0;
  localparam logic [1:0] ALM_ON = 2'h1;
  localparam logic [1:0] ALM_OFF = 2'h2;

  // Time unit for the delays.
  localparam logic [1:0] UNIT_MS = 2'h0;
  localparam logic [1:0] UNIT_S = 2'h1;
  localparam logic [1:0] UNIT_MIN = 2'h2;
  localparam logic [CNT_W-1:0] MS_PER_S = 32'h0000_03E8;
  localparam logic [CNT_W-1:0] MS_PER_MIN = 32'h0000_EA60;

  // Reset values.
  localparam logic RELAY_RST = 1'b0;

  // Zone seen by the comparator.
  typedef enum logic [1:0] {ZONE_MID, ZONE_A, ZONE_B} trc_zone_t;

  // Dwell state of the relay timer.
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT} trc_state_t;

endpackage

/* File: verilog/trc_tick.sv */
// Millisecond tick generator for the threshold relay block.
`timescale 1ns/1ps
module trc_tick (
  input wire logic core_clk,
  input wire logic reset,
  output logic tick_ms
);

  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic tick_q;
  logic tick_d;

  // ----------------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------------
  // Counts core clocks to one millisecond and pulses once per wrap.
  always_comb
  begin
    tick_d = 1'b0;
    cnt_d = cnt_q + 32'h0000_0001;
    if (cnt_q == 32'(trc_pkg::TICK_MS_CYC - 1))
    begin
      cnt_d = 32'h0000_0000;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      cnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_ms = tick_q;

endmodule

/* File: tb/trc_plant.sv */
// Value source with peak hold that feeds the relay block.
`timescale 1ns/1ps
module trc_plant (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic signed [15:0] target,
  output logic signed [15:0] meas_value,
  output logic signed [15:0] peak_value
);
  // Present value follows the target; the peak only ever rises.
  always @(posedge core_clk)
  begin
    meas_value <= #2 reset ? 16'sh0000 : target;
    peak_value <= #2 reset ? 16'sh8000 :
      (target > peak_value ? target : peak_value);
  end
endmodule

/* File: tb/trc_relay_checker.sv */
// Port assertions for the threshold relay block.
`timescale 1ns/1ps
module trc_relay_checker (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic signed [15:0] meas_value,
  input wire logic signed [15:0] peak_value,
  input wire logic peak_active,
  input wire logic [1:0] out_mode,
  input wire logic mode_on_in,
  input wire logic signed [15:0] first_setpoint,
  input wire logic signed [15:0] second_setpoint,
  input wire logic [15:0] hysteresis,
  input wire logic [15:0] turn_on_delay,
  input wire logic [15:0] turn_off_delay,
  input wire logic [1:0] alarm_mode,
  input wire logic critical,
  input wire logic any_input_alarm,
  input wire logic signed [15:0] display_temp,
  input wire logic relay_on,
  input wire logic relay_led_red,
  input wire logic general_alarm_led_green,
  input wire logic general_alarm_led_red
);
  // Widened so that a setpoint plus hysteresis can never wrap.
  logic signed [17:0] v, lo, hi, h;
  logic quiet, t_ok;
  assign v = 18'(peak_active ? peak_value : meas_value);
  assign h = {2'b00, hysteresis};
  assign lo = 18'(first_setpoint < second_setpoint ? first_setpoint :
    second_setpoint);
  assign hi = 18'(first_setpoint < second_setpoint ? second_setpoint :
    first_setpoint);
  assign quiet = !critical && turn_on_delay == 16'h0000 &&
    turn_off_delay == 16'h0000;
  assign t_ok = display_temp > trc_pkg::TEMP_MIN_C &&
    display_temp < trc_pkg::TEMP_MAX_C;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (reset);
  property p_unused;
    (!critical && out_mode == 2'h0)[*3] |-> !relay_on;
  endproperty
  a_unused: assert property (p_unused) else $error("relay used");
  property p_fon;
    (critical && alarm_mode == 2'h1)[*3] |-> relay_on;
  endproperty
  a_fon: assert property (p_fon) else $error("not forced on");
  property p_foff;
    (critical && alarm_mode == 2'h2)[*3] |-> !relay_on;
  endproperty
  a_foff: assert property (p_foff) else $error("not forced off");
  property p_dark;
    (!relay_on)[*2] |-> !relay_led_red;
  endproperty
  a_dark: assert property (p_dark) else $error("led lit open");
  property p_green;
    (t_ok && !any_input_alarm)[*3] |->
      general_alarm_led_green && !general_alarm_led_red;
  endproperty
  a_green: assert property (p_green) else $error("not green");
  property p_red;
    (t_ok && any_input_alarm)[*3] |->
      general_alarm_led_red && !general_alarm_led_green;
  endproperty
  a_red: assert property (p_red) else $error("not red");
  property p_one;
    (quiet && out_mode == 2'h1 && $stable(mode_on_in) &&
      v > first_setpoint + h)[*3] |-> relay_on == mode_on_in;
  endproperty
  a_one: assert property (p_one) else $error("zone A wrong");
  property p_two;
    (quiet && out_mode == 2'h2 && $stable(mode_on_in) &&
      v > lo + h && v < hi - h)[*3] |-> relay_on == mode_on_in;
  endproperty
  a_two: assert property (p_two) else $error("inner zone wrong");
endmodule

bind trc_relay trc_relay_checker i_trc_relay_checker (
  .core_clk(core_clk),
  .reset(reset),
  .meas_value(meas_value),
  .peak_value(peak_value),
  .peak_active(peak_active),
  .out_mode(out_mode),
  .mode_on_in(mode_on_in),
  .first_setpoint(first_setpoint),
  .second_setpoint(second_setpoint),
  .hysteresis(hysteresis),
  .turn_on_delay(turn_on_delay),
  .turn_off_delay(turn_off_delay),
  .alarm_mode(alarm_mode),
  .critical(critical),
  .any_input_alarm(any_input_alarm),
  .display_temp(display_temp),
  .relay_on(relay_on),
  .relay_led_red(relay_led_red),
  .general_alarm_led_green(general_alarm_led_green),
  .general_alarm_led_red(general_alarm_led_red)
);

/* File: tb/trc_relay_tb.sv */
// Self-checking bench for the threshold relay block.
`timescale 1ns/1ps
module trc_relay_tb;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic signed [15:0] target = 16'sh0000, meas_value, peak_value;
  logic signed [15:0] pk = 16'sh0000, display_temp = 16'sh0019;
  logic signed [15:0] first_setpoint = 16'sh0000;
  logic signed [15:0] second_setpoint = 16'sh0000;
  logic peak_active = 1'b0, mode_on_in = 1'b1, critical = 1'b0;
  logic any_input_alarm = 1'b0, exp_rel = 1'b0, hot = 1'b0;
  logic [1:0] out_mode = 2'h1, time_unit = 2'h0, alarm_mode = 2'h0;
  logic [15:0] hysteresis = 16'h0000, turn_on_delay = 16'h0000;
  logic [15:0] turn_off_delay = 16'h0000;
  logic relay_on, relay_led_red;
  logic general_alarm_led_green, general_alarm_led_red;
  int num_errors = 0, check_count = 0;
  logic signed [15:0] cv [5] = '{16'shFF38, 16'sh0069, 16'sh006A,
    16'sh005F, 16'sh005E};

  trc_plant i_trc_plant (
    .core_clk(core_clk),
    .reset(reset),
    .target(target),
    .meas_value(meas_value),
    .peak_value(peak_value)
  );
  trc_relay i_trc_relay (
    .core_clk(core_clk),
    .reset(reset),
    .meas_value(meas_value),
    .peak_value(peak_value),
    .peak_active(peak_active),
    .out_mode(out_mode),
    .mode_on_in(mode_on_in),
    .first_setpoint(first_setpoint),
    .second_setpoint(second_setpoint),
    .hysteresis(hysteresis),
    .turn_on_delay(turn_on_delay),
    .turn_off_delay(turn_off_delay),
    .time_unit(time_unit),
    .alarm_mode(alarm_mode),
    .critical(critical),
    .any_input_alarm(any_input_alarm),
    .display_temp(display_temp),
    .relay_on(relay_on),
    .relay_led_red(relay_led_red),
    .general_alarm_led_green(general_alarm_led_green),
    .general_alarm_led_red(general_alarm_led_red)
  );

  // A 25 ns clock.
  initial
    forever #12.5 core_clk = ~core_clk;

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(logic seen, logic exp, string msg);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic wait_cyc(int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  // Relay state expected from the zones; mid band keeps cur.
  function automatic logic exp_relay(logic signed [17:0] v, logic cur);
    logic signed [17:0] a, b, h;
    a = first_setpoint < second_setpoint ? first_setpoint : second_setpoint;
    b = first_setpoint < second_setpoint ? second_setpoint : first_setpoint;
    h = {2'b00, hysteresis};
    if (critical)
      return alarm_mode == 2'h0 ? cur : alarm_mode == 2'h1;
    if (out_mode == 2'h1)
      return v > first_setpoint + h ? mode_on_in :
        v < first_setpoint - h ? !mode_on_in : cur;
    if (out_mode == 2'h2)
      return v > a + h && v < b - h ? mode_on_in :
        v < a - h || v > b + h ? !mode_on_in : cur;
    return 1'b0;
  endfunction

  // The plant lags one cycle, so settings meet the old value first.
  task automatic step(logic signed [15:0] val);
    exp_rel = exp_relay(peak_active ? pk : target, exp_rel);
    target = val;
    pk = val > pk ? val : pk;
    wait_cyc(4);
    exp_rel = exp_relay(peak_active ? pk : target, exp_rel);
    chk(relay_on, exp_rel, "relay state");
  endtask

  initial
  begin
    void'($urandom(32'hD20D67BD));
    wait_cyc(10);
    reset = 1'b0;
    hysteresis = 16'h0005;
    first_setpoint = 16'sh0064;
    foreach (cv[i])
      step(cv[i]);
    $display("border test done");
    repeat (300)
    begin
      wait_cyc(1);
      out_mode = 2'($urandom_range(3));
      mode_on_in = 1'($urandom);
      peak_active = $urandom_range(9) == 0;
      first_setpoint = 16'($urandom_range(1000)) - 16'h01F4;
      second_setpoint = 16'($urandom_range(1000)) - 16'h01F4;
      hysteresis = 16'($urandom_range(50));
      time_unit = 2'($urandom_range(2));
      critical = out_mode inside {2'h1, 2'h2} && $urandom_range(5) == 0;
      alarm_mode = 2'($urandom_range(2));
      any_input_alarm = 1'($urandom);
      display_temp = 16'($urandom_range(139)) - 16'h0028;
      hot = display_temp < trc_pkg::TEMP_MIN_C ||
        display_temp > trc_pkg::TEMP_MAX_C;
      step(16'($urandom_range(1400)) - 16'h02BC);
      // The run is far shorter than the 500 ms flash phase, which opens
      // dark, so a hot display shows both alarm LEDs unlit here.
      chk(general_alarm_led_red, any_input_alarm & !hot, "red");
      chk(general_alarm_led_green, !(any_input_alarm | hot), "grn");
      if (hot)
        chk(general_alarm_led_green, 1'b0, "flash");
      if (relay_on === 1'b0)
        chk(relay_led_red, 1'b0, "relay led");
    end
    $display("random test done");
    out_mode = 2'h1;
    mode_on_in = 1'b1;
    critical = 1'b0;
    peak_active = 1'b0;
    first_setpoint = 16'sh0000;
    hysteresis = 16'h0000;
    time_unit = trc_pkg::UNIT_MS;
    step(16'shFFF6);
    turn_on_delay = 16'h0002;
    target = 16'sh000A;
    wait_cyc(20000);
    chk(relay_on, 1'b0, "on too early");
    target = 16'shFFF6;
    wait_cyc(20);
    target = 16'sh000A;
    wait_cyc(20000);
    chk(relay_on, 1'b0, "count not restarted");
    turn_on_delay = 16'h0001;
    for (int n = 0; n < 41000 && relay_on !== 1'b1; n++)
      wait_cyc(1);
    chk(relay_on, 1'b1, "never turned on");
    $display("dwell test done");
    give_verdict();
  end

  // Cuts a hang short well after the expected run length.
  initial
  begin
    #2400000;
    num_errors++;
    $display("wrong value at %0t: watchdog", $time);
    give_verdict();
  end
endmodule
